// file: logic/ssp_pkg.sv
package ssp_pkg;
    localparam logic [6:0] SLAVE_ADDR      = 7'h58;
    localparam logic [7:0] OFS_PWM_RATE    = 8'h05;
    localparam logic [7:0] OFS_SAMP_HIGH   = 8'h06;
    localparam logic [7:0] OFS_SAMP_LOW    = 8'h07;
    localparam logic [7:0] RST_PWM_RATE    = 8'h00;
    localparam logic [7:0] RST_SAMP_HIGH   = 8'h00;
    localparam logic [7:0] RST_SAMP_LOW    = 8'h01;
    localparam int         SAMPLE_PRESCALE = 8;
    localparam int         PWM_TICKS       = 4096;
    localparam int         BITS_PER_BYTE   = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK  = 3'b010,
        ST_RX   = 3'b011,
        ST_TX   = 3'b100,
        ST_MACK = 3'b101
    } link_state_e;
endpackage

// file: logic/wr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wr_if;
    logic       valid;
    logic       ready;
    logic [7:0] addr;
    logic [7:0] data;
    modport src (output valid, output addr, output data, input ready);
    modport dst (input valid, input addr, input data, output ready);
endinterface
`default_nettype wire

// file: logic/wr_buffer.sv
`timescale 1ns/10ps
`default_nettype none
// two-entry skid buffer for register writes
module wr_buffer (
    input  wire logic core_clk,
    input  wire logic rstn,
    wr_if.dst         in_w,
    wr_if.src         out_w
);
    logic [15:0] mem [2];
    logic        wptr;
    logic        rptr;
    logic [1:0]  count;
    logic        push;
    logic        pop;

    assign in_w.ready  = (count != 2'd2);
    assign out_w.valid = (count != 2'd0);
    assign out_w.addr  = mem[rptr][15:8];
    assign out_w.data  = mem[rptr][7:0];
    assign push = in_w.valid && in_w.ready;
    assign pop  = out_w.valid && out_w.ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wptr] <= {in_w.addr, in_w.data};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wptr  <= 1'b0;
            rptr  <= 1'b0;
            count <= 2'd0;
        end else begin
            if (push) begin
                wptr <= ~wptr;
            end
            if (pop) begin
                rptr <= ~rptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule
`default_nettype wire

// file: logic/serial_slave_port.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - slave only, receives and transmits, up to 100 kbit/s, never initiates
// - data pin only pulled low; a one releases it
// - idle bus: neither party pulls clock or data low
// - start is data falling while clock high; resets receive state
// - stop is data rising while clock high; device returns idle
// - bus busy from start until stop; repeated start keeps it busy
// - repeated start handled as ordinary start, new address phase
// - take part only when address matches own address
// - transmit only on master read, receive otherwise
// - sample tick at clock divided by eight times sample divisor
// - sample divisor is {reg 0x06, reg 0x07}, 0x06 upper
// - pwm period 4096 ticks of clock divided by pwm setting plus one
// - address 0x58 acknowledged; lsb one reads, zero writes
// - bytes msb first then acknowledge; data changes while clock low
// - write: address, register address, data, each acked, then stop
// - read: write register address, repeated start read, byte, nack, stop
module serial_slave_port (
    // clock and reset
    input  wire logic  core_clk,
    input  wire logic  rstn,
    // two-wire bus
    input  wire logic  scl_in,
    input  wire logic  host_data_pin_in,
    output logic       host_data_pin_out,
    output logic       host_data_pin_oe_n,
    // status and timebase
    output logic       bus_busy,
    output logic       sensor_sample_tick,
    output logic       pwm_period_tick,
    output logic [7:0] pwm_rate_divider,
    output logic [15:0] sample_rate_divider
);
    import ssp_pkg::*;

    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    link_state_e state;
    logic [2:0]  bit_cnt;
    logic        byte_done;
    logic [7:0]  shift;
    logic        is_read;
    logic        first_data;
    logic [7:0]  reg_ptr;
    logic        drive_low;
    logic        busy;
    logic        addr_match;
    logic [7:0]  rd_byte;
    logic [7:0]  reg_pwm;
    logic [7:0]  reg_samp_high;
    logic [7:0]  reg_samp_low;
    logic [18:0] samp_cnt;
    logic [7:0]  pre_cnt;
    logic [11:0] tick_cnt;

    wr_if wq_in ();
    wr_if wq_out ();

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], host_data_pin_in};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    assign scl_rise = scl_sync[1] && !scl_q;
    assign scl_fall = !scl_sync[1] && scl_q;
    assign start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
    assign stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1];
    assign addr_match = (shift[7:1] == SLAVE_ADDR);

    always_comb begin
        unique case (reg_ptr)
            OFS_PWM_RATE:  rd_byte = reg_pwm;
            OFS_SAMP_HIGH: rd_byte = reg_samp_high;
            OFS_SAMP_LOW:  rd_byte = reg_samp_low;
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else if (start_det) begin
            busy <= 1'b1;
        end else if (stop_det) begin
            busy <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= ST_IDLE;
            bit_cnt    <= 3'd0;
            byte_done  <= 1'b0;
            shift      <= 8'h00;
            is_read    <= 1'b0;
            first_data <= 1'b0;
            reg_ptr    <= 8'h00;
            drive_low  <= 1'b0;
            wq_in.valid <= 1'b0;
            wq_in.addr <= 8'h00;
            wq_in.data <= 8'h00;
        end else begin
            if (wq_in.valid && wq_in.ready) begin
                wq_in.valid <= 1'b0;
            end
            if (start_det) begin
                state     <= ST_ADDR;
                bit_cnt   <= 3'd0;
                byte_done <= 1'b0;
                drive_low <= 1'b0;
            end else if (stop_det) begin
                state     <= ST_IDLE;
                drive_low <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: ;
                    // msb first sampling on clock rise
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            shift     <= {shift[6:0], sda_sync[1]};
                            bit_cnt   <= bit_cnt + 3'd1;
                            byte_done <= (bit_cnt == 3'd7);
                        end else if (scl_fall && byte_done) begin
                            // eighth bit done; shift holds the byte
                            byte_done <= 1'b0;
                            drive_low <= 1'b1;
                            state     <= ST_ACK;
                            if (state != ST_ADDR) begin
                                if (first_data) begin
                                    reg_ptr    <= shift;
                                    first_data <= 1'b0;
                                end else begin
                                    wq_in.valid <= 1'b1;
                                    wq_in.addr  <= reg_ptr;
                                    wq_in.data  <= shift;
                                    reg_ptr     <= reg_ptr + 8'd1;
                                end
                            end else if (addr_match) begin
                                is_read    <= shift[0];
                                first_data <= !shift[0];
                            end else begin
                                drive_low <= 1'b0;
                                state     <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 3'd0;
                            if (is_read) begin
                                shift     <= {rd_byte[6:0], 1'b0};
                                drive_low <= !rd_byte[7];
                                bit_cnt   <= 3'd1;
                                state     <= ST_TX;
                            end else begin
                                drive_low <= 1'b0;
                                state     <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == 3'd0) begin
                                drive_low <= 1'b0;
                                reg_ptr   <= reg_ptr + 8'd1;
                                state     <= ST_MACK;
                            end else begin
                                drive_low <= !shift[7];
                                shift     <= {shift[6:0], 1'b0};
                                bit_cnt   <= bit_cnt + 3'd1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            state <= sda_sync[1] ? ST_IDLE : ST_ACK;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    wr_buffer u_wr_buffer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .in_w     (wq_in.dst),
        .out_w    (wq_out.src)
    );

    assign wq_out.ready = 1'b1;

    // register file, divisor halves
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            reg_pwm       <= RST_PWM_RATE;
            reg_samp_high <= RST_SAMP_HIGH;
            reg_samp_low  <= RST_SAMP_LOW;
        end else if (wq_out.valid) begin
            unique case (wq_out.addr)
                OFS_PWM_RATE:  reg_pwm <= wq_out.data;
                OFS_SAMP_HIGH: reg_samp_high <= wq_out.data;
                OFS_SAMP_LOW:  reg_samp_low <= wq_out.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            samp_cnt           <= 19'd0;
            sensor_sample_tick <= 1'b0;
        end else if (samp_cnt + 19'd1 >= {reg_samp_high, reg_samp_low, 3'b000}) begin
            samp_cnt           <= 19'd0;
            sensor_sample_tick <= 1'b1;
        end else begin
            samp_cnt           <= samp_cnt + 19'd1;
            sensor_sample_tick <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt         <= 8'h00;
            tick_cnt        <= 12'h000;
            pwm_period_tick <= 1'b0;
        end else begin
            pwm_period_tick <= 1'b0;
            if (pre_cnt >= reg_pwm) begin
                pre_cnt  <= 8'h00;
                tick_cnt <= tick_cnt + 12'd1;
                if (tick_cnt == 12'(PWM_TICKS - 1)) begin
                    pwm_period_tick <= 1'b1;
                end
            end else begin
                pre_cnt <= pre_cnt + 8'd1;
            end
        end
    end

    // registered outputs; released when idle, no clock drive
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            host_data_pin_out   <= 1'b0;
            host_data_pin_oe_n  <= 1'b1;
            bus_busy            <= 1'b0;
            pwm_rate_divider    <= RST_PWM_RATE;
            sample_rate_divider <= {RST_SAMP_HIGH, RST_SAMP_LOW};
        end else begin
            host_data_pin_out   <= 1'b0;
            host_data_pin_oe_n  <= !drive_low;
            bus_busy            <= busy;
            pwm_rate_divider    <= reg_pwm;
            sample_rate_divider <= {reg_samp_high, reg_samp_low};
        end
    end
endmodule
`default_nettype wire

// file: test/ssp_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_assertions (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // bus pins
    input wire logic        scl_in,
    input wire logic        host_data_pin_in,
    input wire logic        host_data_pin_out,
    input wire logic        host_data_pin_oe_n,
    // status and timebase
    input wire logic        bus_busy,
    input wire logic        sensor_sample_tick,
    input wire logic        pwm_period_tick,
    input wire logic [7:0]  pwm_rate_divider,
    input wire logic [15:0] sample_rate_divider
);
    logic [31:0] s_cnt;
    logic [31:0] s_exp;
    logic [15:0] s_div;
    logic        s_ok;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    assign s_exp = (sample_rate_divider == 16'h0) ? 32'h1 : {13'h0, sample_rate_divider, 3'h0};
    // cycles since last sample tick, valid while divider unchanged
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_cnt <= 32'h0;
            s_div <= 16'h0;
            s_ok  <= 1'b0;
        end else begin
            s_cnt <= sensor_sample_tick ? 32'h1 : s_cnt + 32'h1;
            s_div <= sample_rate_divider;
            s_ok  <= (sample_rate_divider == s_div) && (s_ok || sensor_sample_tick);
        end
    end
    AST_DRIVE_LOW: assert property (!host_data_pin_oe_n |-> !host_data_pin_out)
        else $error("data pin driven high");
    AST_IDLE_FREE: assert property (!bus_busy |-> host_data_pin_oe_n)
        else $error("data pulled while idle");
    AST_START_BUSY: assert property ($fell(host_data_pin_in) && scl_in && $past(scl_in)
        |-> ##[1:6] bus_busy) else $error("start not seen");
    AST_STOP_FREE: assert property ($rose(host_data_pin_in) && scl_in && $past(scl_in)
        |-> ##[1:6] !bus_busy) else $error("stop not seen");
    AST_BUSY_HOLD: assert property ($fell(bus_busy) |-> scl_in && host_data_pin_in)
        else $error("busy dropped without stop");
    AST_DATA_SCL_LOW: assert property ($changed(host_data_pin_oe_n) |-> !scl_in)
        else $error("data moved while clock high");
    AST_SAMPLE_GAP: assert property (sensor_sample_tick && s_ok && sample_rate_divider == s_div
        |-> s_cnt == s_exp) else $error("sample tick spacing wrong");
    AST_PWM_PULSE: assert property (pwm_period_tick |=> !pwm_period_tick)
        else $error("pwm tick too long");
endmodule
`default_nettype wire

// file: test/i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
    // clock
    input wire logic core_clk,
    // bus wires
    output logic     scl,
    output logic     pull_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // start (0,1) or stop (1,0) while scl high
    task automatic line_cond(input logic first, input logic last);
        gap(20);
        pull_low = first;
        gap(40);
        scl = 1'b1;
        gap(60);
        pull_low = last;
        gap(60);
        scl = ~last;
    endtask
    // master clocks, msb first, data moves while scl low
    task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] r,
                           output logic ack);
        for (int i = 8; i >= 0; i--) begin
            gap(20);
            pull_low = (i > 0) ? ~d[i-1] : ~mack;
            gap(40);
            scl = 1'b1;
            gap(60);
            if (i > 0) r[i-1] = sda;
            else ack = sda;
            scl = 1'b0;
        end
    endtask
    task automatic write_reg(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] d,
                             output logic [2:0] acks);
        logic [7:0] junk;
        line_cond(1'b0, 1'b1);
        byte_io({sa, 1'b0}, 1'b1, junk, acks[2]);
        byte_io(ra, 1'b1, junk, acks[1]);
        byte_io(d, 1'b1, junk, acks[0]);
        line_cond(1'b1, 1'b0);
    endtask
    // read: repeated start, byte, nack, stop
    task automatic read_reg(input logic [6:0] sa, input logic [7:0] ra, output logic [7:0] d,
                            output logic [2:0] acks);
        logic [7:0] junk;
        logic       nack;
        line_cond(1'b0, 1'b1);
        byte_io({sa, 1'b0}, 1'b1, junk, acks[2]);
        byte_io(ra, 1'b1, junk, acks[1]);
        line_cond(1'b0, 1'b1);
        byte_io({sa, 1'b1}, 1'b1, junk, acks[0]);
        byte_io(8'hff, 1'b1, d, nack);
        line_cond(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// file: test/tb_serial_slave_port_and_timebase.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_serial_slave_port_and_timebase;
    import ssp_pkg::*;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        scl, pull_low, sda, oe_n, busy, s_tick, p_tick;
    logic [7:0]  pwm_div, rd;
    logic [15:0] samp_div;
    logic [7:0]  v [3];
    logic [2:0]  ak;
    int          fail_count = 0;
    int          n_checks = 0;
    int          seed = 3;
    int          g;
    always #2.5 core_clk = ~core_clk;
    assign sda = (pull_low || !oe_n) ? 1'b0 : 1'b1;
    serial_slave_port dut_u (.core_clk(core_clk), .rstn(rstn), .scl_in(scl),
        .host_data_pin_in(sda), .host_data_pin_out(), .host_data_pin_oe_n(oe_n),
        .bus_busy(busy), .sensor_sample_tick(s_tick), .pwm_period_tick(p_tick),
        .pwm_rate_divider(pwm_div), .sample_rate_divider(samp_div));
    i2c_host_model host_u (.core_clk(core_clk), .scl(scl), .pull_low(pull_low), .sda(sda));
    function automatic int expect_gap(logic pick, int d);
        return pick ? 4096 * (d + 1) : (d == 0 ? 1 : 8 * d);
    endfunction
    task automatic give_verdict();
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic measure(input logic pick, output int n);
        n = 0;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge core_clk);
                #1;
                n++;
            end while ((pick ? p_tick : s_tick) !== 1'b1 && n < 20000);
        end
        if (n >= 20000) begin
            fail_count++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK({pwm_div, samp_div}, {RST_PWM_RATE, RST_SAMP_HIGH, RST_SAMP_LOW})
        `CHK({sda, busy}, 2'b10)
        for (int i = 0; i < 3; i++) begin
            v[i] = 8'($random(seed));
            host_u.write_reg(SLAVE_ADDR, OFS_PWM_RATE + 8'(i), v[i], ak);
            `CHK({ak, busy}, 4'h0)
        end
        for (int i = 0; i < 3; i++) begin
            host_u.read_reg(SLAVE_ADDR, OFS_PWM_RATE + 8'(i), rd, ak);
            `CHK({ak, rd}, {3'b000, v[i]})
        end
        `CHK({pwm_div, samp_div}, {v[0], v[1], v[2]})
        host_u.write_reg(7'h59, OFS_PWM_RATE, ~v[0], ak);
        `CHK({ak, pwm_div}, {3'b111, v[0]})
        host_u.read_reg(7'h59, OFS_PWM_RATE, rd, ak);
        `CHK({ak, rd}, 11'h7ff)
        host_u.write_reg(SLAVE_ADDR, 8'h00, 8'h5a, ak);
        host_u.read_reg(SLAVE_ADDR, 8'h00, rd, ak);
        `CHK({ak, rd}, 11'h000)
        host_u.line_cond(1'b0, 1'b1);
        host_u.byte_io({7'h59, 1'b0}, 1'b1, rd, ak[0]);
        host_u.line_cond(1'b0, 1'b1);
        `CHK({busy, ak[0]}, 2'b11)
        host_u.byte_io({SLAVE_ADDR, 1'b0}, 1'b1, rd, ak[2]);
        host_u.byte_io(OFS_SAMP_HIGH, 1'b1, rd, ak[1]);
        host_u.byte_io(8'h00, 1'b1, rd, ak[0]);
        `CHK(ak, 3'b000)
        host_u.byte_io(8'h03, 1'b1, rd, ak[0]);
        host_u.line_cond(1'b1, 1'b0);
        `CHK({ak[0], samp_div}, 17'h00003)
        host_u.write_reg(SLAVE_ADDR, OFS_PWM_RATE, 8'h01, ak);
        measure(1'b0, g);
        `CHK(g, expect_gap(1'b0, 3))
        measure(1'b1, g);
        `CHK(g, expect_gap(1'b1, 1))
        give_verdict();
    end
endmodule
bind serial_slave_port ssp_assertions chk_u (.core_clk(core_clk), .rstn(rstn),
    .scl_in(scl_in), .host_data_pin_in(host_data_pin_in),
    .host_data_pin_out(host_data_pin_out), .host_data_pin_oe_n(host_data_pin_oe_n),
    .bus_busy(bus_busy), .sensor_sample_tick(sensor_sample_tick),
    .pwm_period_tick(pwm_period_tick), .pwm_rate_divider(pwm_rate_divider),
    .sample_rate_divider(sample_rate_divider));
`default_nettype wire
